// ### logic/drph_ctl.sv
// reset and power controller end of the debug handshake
`timescale 1ns/10ps
module drph_ctl #(
    parameter bit SINGLE_DOMAIN   = 1'b1,
    parameter int RST_HOLD_CYCLES = drph_pkg::RST_HOLD_CYCLES_DEF
) (
    input  wire logic  pclk,
    input  wire logic  presetn,
    input  wire logic  ce,
    input  wire logic  dbg_domain_active,
    input  wire logic  sys_domain_active,
    output logic       merged_power_request,
    output logic       dbg_power_request,
    output logic       sys_power_request,
    output logic       debug_domain_reset_out,
    drph_link_if.ctl   link
);
    typedef struct packed {
        drph_pkg::drph_rc_state_t  state;
        logic [drph_pkg::CNT_W-1:0] count;
        logic                       dom_rst;
        logic                       rst_ack;
        logic                       dbg_ack;
        logic                       sys_ack;
        logic                       merged;
        logic                       dbg_req;
        logic                       sys_req;
    } drph_ctl_regs_t;

    drph_ctl_regs_t r_q;
    drph_ctl_regs_t r_d;
    logic [1:0]     act_s;
    logic           dbg_act;
    logic           sys_act;

    // ------------------------------------------------------------------
    // domain activity inputs
    // ------------------------------------------------------------------
    drph_sync #(.WIDTH(2)) u_act_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .din     ({sys_domain_active, dbg_domain_active}),
        .dout    (act_s)
    );

    assign dbg_act = act_s[0];
    assign sys_act = SINGLE_DOMAIN ? act_s[0] : act_s[1];

    // ------------------------------------------------------------------
    // power acks and reset sequence
    // ------------------------------------------------------------------
    always_comb begin
        r_d         = r_q;
        r_d.merged  = link.dbg_power_up_request | link.sys_power_up_request; // [R1]
        r_d.dbg_req = link.dbg_power_up_request;
        r_d.sys_req = link.sys_power_up_request;
        r_d.dbg_ack = link.dbg_power_up_request & dbg_act; // [R2] [R15] [R16]
        r_d.sys_ack = link.sys_power_up_request & sys_act; // [R2] [R15] [R16]
        unique case (r_q.state)
            drph_pkg::DRPH_RC_IDLE: begin
                if (link.debug_reset_request) begin
                    if (r_q.dbg_ack) begin
                        r_d.state   = drph_pkg::DRPH_RC_RESET; // [R5]
                        r_d.count   = '0;
                        r_d.dom_rst = 1'b1;
                    end else begin
                        r_d.state   = drph_pkg::DRPH_RC_ACK; // [R14]
                        r_d.rst_ack = 1'b1;
                    end
                end
            end
            drph_pkg::DRPH_RC_RESET: begin
                r_d.count = r_q.count + 1'b1;
                if (r_q.count == drph_pkg::CNT_W'(RST_HOLD_CYCLES - 1)) begin
                    r_d.state   = drph_pkg::DRPH_RC_ACK; // [R5]
                    r_d.dom_rst = 1'b0;
                    r_d.rst_ack = 1'b1;
                end
            end
            drph_pkg::DRPH_RC_ACK: begin
                if (!link.debug_reset_request) begin
                    r_d.state   = drph_pkg::DRPH_RC_IDLE; // [R10]
                    r_d.rst_ack = 1'b0;
                end
            end
            default: begin
                r_d.state   = drph_pkg::DRPH_RC_IDLE;
                r_d.dom_rst = 1'b0;
                r_d.rst_ack = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_q <= '0;
        end else if (ce) begin
            r_q <= r_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign link.dbg_power_up_ack   = r_q.dbg_ack;
    assign link.sys_power_up_ack   = r_q.sys_ack;
    assign link.debug_reset_ack    = r_q.rst_ack;
    assign link.debug_domain_reset = r_q.dom_rst;
    assign merged_power_request    = r_q.merged;
    assign dbg_power_request       = r_q.dbg_req;
    assign sys_power_request       = r_q.sys_req;
    assign debug_domain_reset_out  = r_q.dom_rst;
endmodule // drph_ctl

// ### logic/drph_dev.sv
// debug port end: control/status register, interrupts and access-port state
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps

// Notes on behaviour
// [R1] merged power request is OR of both
// [R2] each domain still gets its own ack
// [R3] control/status holds reset request and ack
// [R4] request bit drives the reset request output
// [R5] controller resets debug domain, then acks
// [R6] debug reset clears access-port state
// [R7] debug port registers cleared only by power-on
// [R8] ack input reads back in status bit
// [R9] debugger clears request after seeing ack
// [R10] controller drops ack after request drops
// [R11] request never withdrawn before ack rises
// [R12] reset control bits writable at any time
// [R13] debug power-up also clears access-port state
// [R14] powered-down domain ignores debug reset
// [R15] power acks low until request and power
// [R16] domain ack is request AND domain active
// [R17] reset ack synchronised before status use
module drph_dev #(
    parameter int ADDR_W = drph_pkg::ADDR_W
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              ce,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   irq,
    output logic      [31:0]       access_port_state,
    drph_link_if.dev               link
);
    typedef struct packed {
        logic                           rst_req;
        logic                           dbg_pwr_req;
        logic                           sys_pwr_req;
        logic [drph_pkg::EV_W-1:0]      int_status;
        logic [drph_pkg::EV_W-1:0]      int_enable;
        logic [drph_pkg::ACK_W-1:0]     ack_prev;
        logic [31:0]                    ap_state;
        logic [31:0]                    prdata;
        logic                           pslverr;
        logic                           irq;
    } drph_dev_regs_t;

    drph_dev_regs_t                 r_q;
    drph_dev_regs_t                 r_d;
    logic [drph_pkg::ACK_W-1:0]     ack_s;
    logic [drph_pkg::EV_W-1:0]      ev;
    logic [drph_pkg::EV_W-1:0]      clr;
    logic [31:0]                    ctrl_val;
    logic                           wr;
    logic                           setup;
    logic                           dbg_up;
    logic                           ap_clear;
    logic                           hit;
    logic [31:0]                    rd_val;
    logic [31:0]                    rd_word;
    logic                           rd_err;
    logic                           access;
    logic                           wr_ctrl;
    logic                           wr_clear;
    logic                           wr_enable;
    logic                           wr_ap;
    logic [drph_pkg::ACK_W-1:0]     ack_rise;
    logic [drph_pkg::ACK_W-1:0]     ack_fall;

    // ------------------------------------------------------------------
    // acknowledge synchroniser
    // ------------------------------------------------------------------
    drph_sync #(.WIDTH(drph_pkg::ACK_W)) u_ack_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .din     ({link.sys_power_up_ack, link.dbg_power_up_ack, link.debug_reset_ack}),
        .dout    (ack_s) // [R17]
    );

    // ------------------------------------------------------------------
    // bus decode and status view
    // ------------------------------------------------------------------
    assign access = psel & penable & ce;
    assign wr     = access & pwrite;
    assign setup  = psel & ~penable;

    // ------------------------------------------------------------------
    // write strobes, one per writable register
    // ------------------------------------------------------------------
    assign wr_ctrl   = wr & (paddr == drph_pkg::ADDR_CTRL_STAT);
    assign wr_clear  = wr & (paddr == drph_pkg::ADDR_INT_CLEAR);
    assign wr_enable = wr & (paddr == drph_pkg::ADDR_INT_ENABLE);
    assign wr_ap     = wr & (paddr == drph_pkg::ADDR_AP_STATE);

    always_comb begin
        ctrl_val                          = '0;
        ctrl_val[drph_pkg::BIT_RST_REQ]     = r_q.rst_req; // [R3]
        ctrl_val[drph_pkg::BIT_RST_ACK]     = ack_s[drph_pkg::ACK_RST]; // [R3] [R8]
        ctrl_val[drph_pkg::BIT_DBG_PWR_REQ] = r_q.dbg_pwr_req;
        ctrl_val[drph_pkg::BIT_DBG_PWR_ACK] = ack_s[drph_pkg::ACK_DBG];
        ctrl_val[drph_pkg::BIT_SYS_PWR_REQ] = r_q.sys_pwr_req;
        ctrl_val[drph_pkg::BIT_SYS_PWR_ACK] = ack_s[drph_pkg::ACK_SYS];
    end

    always_comb begin
        hit    = 1'b1;
        rd_val = '0;
        unique case (paddr)
            drph_pkg::ADDR_CTRL_STAT: begin
                rd_val = ctrl_val;
            end
            drph_pkg::ADDR_INT_STATUS: begin
                rd_val[drph_pkg::EV_W-1:0] = r_q.int_status;
            end
            drph_pkg::ADDR_INT_CLEAR: begin
                rd_val = '0;
            end
            drph_pkg::ADDR_INT_ENABLE: begin
                rd_val[drph_pkg::EV_W-1:0] = r_q.int_enable;
            end
            drph_pkg::ADDR_AP_STATE: begin
                rd_val = r_q.ap_state;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // read capture
    // ------------------------------------------------------------------
    assign rd_word = hit ? rd_val : '0;
    assign rd_err  = ~hit;

    // ------------------------------------------------------------------
    // acknowledge edges, one lane per acknowledge
    // ------------------------------------------------------------------
    for (genvar g = 0; g < drph_pkg::ACK_W; g++) begin : g_ack_edge
        assign ack_rise[g] = ack_s[g] & ~r_q.ack_prev[g];
        assign ack_fall[g] = ~ack_s[g] & r_q.ack_prev[g];
    end

    // ------------------------------------------------------------------
    // events
    // ------------------------------------------------------------------
    always_comb begin
        ev                           = '0;
        ev[drph_pkg::EV_RST_ACK_SET] = ack_rise[drph_pkg::ACK_RST];
        ev[drph_pkg::EV_RST_ACK_CLR] = ack_fall[drph_pkg::ACK_RST];
        ev[drph_pkg::EV_DBG_PWR]     = ack_rise[drph_pkg::ACK_DBG] | ack_fall[drph_pkg::ACK_DBG];
        ev[drph_pkg::EV_SYS_PWR]     = ack_rise[drph_pkg::ACK_SYS] | ack_fall[drph_pkg::ACK_SYS];
    end

    assign clr      = wr_clear ? pwdata[drph_pkg::EV_W-1:0] : '0;
    assign dbg_up   = ack_rise[drph_pkg::ACK_DBG];
    assign ap_clear = (link.debug_domain_reset & ack_s[drph_pkg::ACK_DBG]) | dbg_up;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        r_d          = r_q;
        r_d.ack_prev = ack_s;
        if (wr_ctrl) begin
            r_d.rst_req     = pwdata[drph_pkg::BIT_RST_REQ]; // [R4] [R12]
            r_d.dbg_pwr_req = pwdata[drph_pkg::BIT_DBG_PWR_REQ];
            r_d.sys_pwr_req = pwdata[drph_pkg::BIT_SYS_PWR_REQ];
        end
        if (wr_enable) begin
            r_d.int_enable = pwdata[drph_pkg::EV_W-1:0];
        end
        r_d.int_status = (r_q.int_status & ~clr) | ev;
        if (ap_clear) begin
            r_d.ap_state = drph_pkg::AP_STATE_RESET; // [R6] [R13] [R14]
        end else if (wr_ap) begin
            r_d.ap_state = pwdata;
        end
        if (setup) begin
            r_d.prdata  = rd_word;
            r_d.pslverr = rd_err;
        end
        r_d.irq = |(r_d.int_status & r_d.int_enable);
    end

    // power-on reset only; debug-domain reset reaches only ap_state, through its synchronous clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_q <= '0; // [R7]
        end else if (ce) begin
            r_q <= r_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign prdata                    = r_q.prdata;
    assign pready                    = access;
    assign pslverr                   = r_q.pslverr;
    assign irq                       = r_q.irq;
    assign access_port_state         = r_q.ap_state;
    assign link.debug_reset_request  = r_q.rst_req; // [R4]
    assign link.dbg_power_up_request = r_q.dbg_pwr_req;
    assign link.sys_power_up_request = r_q.sys_pwr_req;
endmodule // drph_dev

// ### logic/drph_link_if.sv
// link between the debug port end and the reset/power controller end
`timescale 1ns/10ps
interface drph_link_if;
    logic dbg_power_up_request;
    logic sys_power_up_request;
    logic dbg_power_up_ack;
    logic sys_power_up_ack;
    logic debug_reset_request;
    logic debug_reset_ack;
    logic debug_domain_reset;

    modport dev (
        output dbg_power_up_request,
        output sys_power_up_request,
        output debug_reset_request,
        input  dbg_power_up_ack,
        input  sys_power_up_ack,
        input  debug_reset_ack,
        input  debug_domain_reset
    );

    modport ctl (
        input  dbg_power_up_request,
        input  sys_power_up_request,
        input  debug_reset_request,
        output dbg_power_up_ack,
        output sys_power_up_ack,
        output debug_reset_ack,
        output debug_domain_reset
    );
endinterface

// ### logic/drph_pkg.sv
// shared constants and types of the debug reset and power handshake
package drph_pkg;

    // ------------------------------------------------------------------
    // register offsets of the debug port end
    // ------------------------------------------------------------------
    localparam int             ADDR_W          = 8;
    localparam logic [ADDR_W-1:0] ADDR_CTRL_STAT  = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_INT_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_INT_CLEAR  = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_INT_ENABLE = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_AP_STATE   = 8'h10;

    // ------------------------------------------------------------------
    // control/status field positions
    // ------------------------------------------------------------------
    localparam int BIT_RST_REQ     = 26;
    localparam int BIT_RST_ACK     = 27;
    localparam int BIT_DBG_PWR_REQ = 28;
    localparam int BIT_DBG_PWR_ACK = 29;
    localparam int BIT_SYS_PWR_REQ = 30;
    localparam int BIT_SYS_PWR_ACK = 31;

    // ------------------------------------------------------------------
    // interrupt event bits
    // ------------------------------------------------------------------
    localparam int EV_W           = 4;
    localparam int EV_RST_ACK_SET = 0;
    localparam int EV_RST_ACK_CLR = 1;
    localparam int EV_DBG_PWR     = 2;
    localparam int EV_SYS_PWR     = 3;

    // ------------------------------------------------------------------
    // acknowledge synchroniser lanes
    // ------------------------------------------------------------------
    localparam int ACK_W   = 3;
    localparam int ACK_RST = 0;
    localparam int ACK_DBG = 1;
    localparam int ACK_SYS = 2;

    // ------------------------------------------------------------------
    // reset values and controller timing
    // ------------------------------------------------------------------
    localparam logic [31:0]     AP_STATE_RESET      = 32'h0000_0000;
    localparam logic [EV_W-1:0] INT_ENABLE_RESET    = 4'h0;
    localparam int              CNT_W               = 16;
    localparam int              RST_HOLD_CYCLES_DEF = 4;

    typedef enum logic [1:0] {
        DRPH_RC_IDLE  = 2'b00,
        DRPH_RC_RESET = 2'b01,
        DRPH_RC_ACK   = 2'b10
    } drph_rc_state_t;

endpackage

// ### logic/drph_sync.sv
// two-flop level synchroniser, one lane per bit
`timescale 1ns/10ps
module drph_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    typedef struct packed {
        logic [WIDTH-1:0] stage2;
        logic [WIDTH-1:0] stage1;
    } drph_sync_t;

    drph_sync_t s_q;
    drph_sync_t s_d;

    // ------------------------------------------------------------------
    // per-bit stages
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        for (int i = 0; i < WIDTH; i++) begin
            s_d.stage1[i] = din[i];
            s_d.stage2[i] = s_q.stage1[i];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign dout = s_q.stage2;
endmodule // drph_sync

// ### sim/debug_reset_power_handshake_bench.sv
// self-checking bench for both ends of the debug reset and power handshake
`timescale 1ns/10ps
module debug_reset_power_handshake_bench;
    typedef struct packed {
        logic        w;
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] q;
        logic        e;
    } drph_row_t;
    logic        pclk;
    logic        presetn;
    logic        ce;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic [31:0] ap_state;
    logic        dbg_act;
    logic        sys_act;
    logic        merged;
    logic        dbg_preq;
    logic        sys_preq;
    logic        dom_rst;
    logic [31:0] rd;
    logic        er;
    int          err_count;
    int          n_checks;
    drph_row_t   rows [9];

    drph_link_if drph_link_if_inst ();
    drph_dev drph_dev_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .access_port_state(ap_state), .link(drph_link_if_inst));
    drph_ctl #(.SINGLE_DOMAIN(1'b1), .RST_HOLD_CYCLES(4)) drph_ctl_inst (.pclk(pclk),
        .presetn(presetn), .ce(ce), .dbg_domain_active(dbg_act),
        .sys_domain_active(sys_act), .merged_power_request(merged),
        .dbg_power_request(dbg_preq), .sys_power_request(sys_preq),
        .debug_domain_reset_out(dom_rst), .link(drph_link_if_inst));
    drph_link_chk drph_link_chk_inst (.pclk(pclk), .presetn(presetn),
        .dbg_power_up_request(drph_link_if_inst.dbg_power_up_request),
        .sys_power_up_request(drph_link_if_inst.sys_power_up_request),
        .dbg_power_up_ack(drph_link_if_inst.dbg_power_up_ack),
        .sys_power_up_ack(drph_link_if_inst.sys_power_up_ack),
        .debug_reset_request(drph_link_if_inst.debug_reset_request),
        .debug_reset_ack(drph_link_if_inst.debug_reset_ack),
        .debug_domain_reset(drph_link_if_inst.debug_domain_reset));

    // ----
    // tasks
    // ----
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task poll(input int b, input logic v);
        for (int i = 0; i < 40; i++) begin
            apb(1'b0, drph_pkg::ADDR_CTRL_STAT, 32'h0);
            if (rd[b] === v) break;
        end
    endtask

    task close_out;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // ----
    // clock, watchdog, sequence
    // ----
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        close_out;
    end

    initial begin
        presetn = 1'b0; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; dbg_act = 1'b0; sys_act = 1'b0;
        err_count = 0; n_checks = 0;
        rows = '{'{1'b1, drph_pkg::ADDR_AP_STATE, 32'h1234_5678, 32'h0, 1'b0},
                 '{1'b0, drph_pkg::ADDR_AP_STATE, 32'h0, 32'h1234_5678, 1'b0},
                 '{1'b1, drph_pkg::ADDR_INT_ENABLE, 32'hF, 32'h0, 1'b0},
                 '{1'b0, drph_pkg::ADDR_INT_ENABLE, 32'h0, 32'hF, 1'b0},
                 '{1'b0, drph_pkg::ADDR_INT_CLEAR, 32'h0, 32'h0, 1'b0},
                 '{1'b1, drph_pkg::ADDR_CTRL_STAT, 32'h03FF_FFFF, 32'h0, 1'b0},
                 '{1'b0, drph_pkg::ADDR_CTRL_STAT, 32'h0, 32'h0, 1'b0},
                 '{1'b0, 8'h14, 32'h0, 32'h0, 1'b1},
                 '{1'b1, 8'h14, 32'h5, 32'h0, 1'b1}};
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk(rd, rows[i].q);
            chk(er, rows[i].e);
        end
        // reset request with the debug domain down
        apb(1'b1, drph_pkg::ADDR_CTRL_STAT, 32'h0400_0000);
        chk(drph_link_if_inst.debug_reset_request, 1'b1);
        poll(27, 1'b1);
        chk(rd, 32'h0C00_0000);
        apb(1'b0, drph_pkg::ADDR_AP_STATE, 32'h0);
        chk(rd, 32'h1234_5678);
        apb(1'b1, drph_pkg::ADDR_CTRL_STAT, 32'h0);
        poll(27, 1'b0);
        chk(rd, 32'h0);
        apb(1'b0, drph_pkg::ADDR_INT_STATUS, 32'h0);
        chk(rd, 32'h3);
        chk(irq, 1'b1);
        apb(1'b1, drph_pkg::ADDR_INT_ENABLE, 32'h0);
        @(posedge pclk);
        chk(irq, 1'b0);
        apb(1'b1, drph_pkg::ADDR_INT_CLEAR, 32'hF);
        apb(1'b0, drph_pkg::ADDR_INT_STATUS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, drph_pkg::ADDR_INT_ENABLE, 32'hF);
        // power up, debug domain first
        dbg_act <= 1'b1;
        sys_act <= 1'b1;
        apb(1'b1, drph_pkg::ADDR_CTRL_STAT, 32'h1000_0000);
        poll(29, 1'b1);
        chk(rd, 32'h3000_0000);
        chk(ap_state, 32'h0);
        chk({merged, dbg_preq, sys_preq}, 3'b110);
        apb(1'b1, drph_pkg::ADDR_CTRL_STAT, 32'h5000_0000);
        poll(31, 1'b1);
        chk(rd, 32'hF000_0000);
        // reset request with the debug domain up
        apb(1'b1, drph_pkg::ADDR_AP_STATE, 32'hCAFE_F00D);
        apb(1'b1, drph_pkg::ADDR_CTRL_STAT, 32'h5400_0000);
        poll(27, 1'b1);
        chk(rd, 32'hFC00_0000);
        chk(ap_state, 32'h0);
        chk(dom_rst, 1'b0);
        apb(1'b1, drph_pkg::ADDR_CTRL_STAT, 32'h5000_0000);
        poll(27, 1'b0);
        chk(rd, 32'hF000_0000);
        // domain goes inactive under a standing request
        dbg_act <= 1'b0;
        poll(29, 1'b0);
        chk(rd, 32'h5000_0000);
        chk(merged, 1'b1);
        chk(irq, 1'b1);
        // clock enable low freezes both ends
        ce      <= 1'b0;
        dbg_act <= 1'b1;
        repeat (6) @(posedge pclk);
        chk(drph_link_if_inst.dbg_power_up_ack, 1'b0);
        ce <= 1'b1;
        poll(29, 1'b1);
        chk(rd, 32'hF000_0000);
        // power-on reset in mid-run
        apb(1'b1, drph_pkg::ADDR_AP_STATE, 32'h0000_00A5);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        chk(ap_state, 32'h0);
        chk(drph_link_if_inst.sys_power_up_request, 1'b0);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, drph_pkg::ADDR_CTRL_STAT, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, drph_pkg::ADDR_INT_ENABLE, 32'h0);
        chk(rd, 32'h0);
        close_out;
    end
endmodule // debug_reset_power_handshake_bench

// ### sim/drph_link_chk.sv
// link checker for the debug reset and power handshake
`timescale 1ns/10ps
module drph_link_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic dbg_power_up_request,
    input wire logic sys_power_up_request,
    input wire logic dbg_power_up_ack,
    input wire logic sys_power_up_ack,
    input wire logic debug_reset_request,
    input wire logic debug_reset_ack,
    input wire logic debug_domain_reset
);
    // ----
    // link relations
    // ----
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    rst_enter_a: assert property (
        $rose(debug_reset_request) && dbg_power_up_ack |=> debug_domain_reset)
        else $error("domain reset late");
    rst_hold_a: assert property (
        $rose(debug_domain_reset) |->
        debug_domain_reset [*4] ##1 (!debug_domain_reset && debug_reset_ack))
        else $error("domain reset length wrong");
    unpowered_ack_a: assert property (
        $rose(debug_reset_request) && !dbg_power_up_ack |=>
        debug_reset_ack && !debug_domain_reset)
        else $error("unpowered reset wrong");
    ack_cause_a: assert property (
        $rose(debug_reset_ack) |-> debug_reset_request)
        else $error("ack without request");
    ack_hold_a: assert property (
        debug_reset_ack && debug_reset_request |=> debug_reset_ack)
        else $error("ack dropped early");
    ack_drop_a: assert property (
        debug_reset_ack && !debug_reset_request |=> !debug_reset_ack)
        else $error("ack not dropped");
    req_hold_a: assert property (
        $fell(debug_reset_request) |-> debug_reset_ack)
        else $error("request withdrawn early");
    dbg_ack_low_a: assert property (
        !dbg_power_up_request |=> !dbg_power_up_ack)
        else $error("debug power ack high");
    sys_ack_low_a: assert property (
        !sys_power_up_request |=> !sys_power_up_ack)
        else $error("system power ack high");
    dbg_ack_cause_a: assert property (
        $rose(dbg_power_up_ack) |-> $past(dbg_power_up_request))
        else $error("power ack without request");
endmodule // drph_link_chk
